// ===== design/dmff_framer.sv
// Operation
// - data request: posted write, FEh/000b address, payload
// - data control matches header except chain/error/count
// - flags and completer id in address bits
// - byte count, requestor id, passpw, coherent mapping
// - initial fragment set only in first piece
// - pci-x forwarding only with payload present
// - chain set while requests follow; none without payload
// - no foreign request inside a fragment
// - byte count is bytes remaining, 000h means 4096
`timescale 1ns/100ps
`default_nettype none

module dmff_framer (
  input wire logic core_clk, // core clock, 200 MHz
  input wire logic reset_n, // sync reset, core domain
  input wire logic msg_valid, // message header offered
  output logic msg_ready, // header taken, framer idle
  input wire logic [3:0] msg_seq_id, // sequence id
  input wire logic [4:0] msg_unit_id, // source unit id
  input wire logic msg_relaxed, // relaxed ordering
  input wire logic msg_no_snoop, // no snoop
  input wire logic msg_isoc, // isochronous
  input wire logic msg_xlat_ok, // translation permitted
  input wire logic msg_route_host, // route to host
  input wire logic msg_silent, // silent drop
  input wire logic msg_type1, // type 1 request
  input wire logic msg_has_data, // message carries payload
  input wire logic msg_data_err, // mark data requests bad
  input wire logic [11:0] msg_byte_count, // bytes, 000h is 4096
  input wire logic [7:0] msg_dst_bus, // completer bus
  input wire logic [4:0] msg_dst_dev, // completer device
  input wire logic [2:0] msg_dst_fn, // completer function
  input wire logic [7:0] msg_src_bus, // requestor bus
  input wire logic [4:0] msg_src_dev, // requestor device
  input wire logic [2:0] msg_src_fn, // requestor function
  input wire logic [39:0] msg_class, // class-specific bits
  input wire logic pay_valid, // payload dword offered
  input wire logic [31:0] pay_data, // payload dword, byte 0 low
  output logic pay_ready, // payload dword taken
  output logic busy, // message in progress
  output logic [39:0] xlat_addr, // mapped address of fragment
  output logic [23:0] xlat_data, // mapped requestor/count bits
  output logic pcix_fwd_ok, // message may go to pci-x side
  input wire logic link_clk, // link clock
  input wire logic link_ready, // partner accepts a bit-time
  output logic link_valid, // bit-time on the link
  output logic link_ctl, // control bit-time flag
  output logic [7:0] link_cad // bit-time byte
);

  typedef struct packed {
    dmff_pkg::dmff_state_e st;
    logic [3:0] bt;
    logic [1:0] bidx;
    logic [3:0] seq_id;
    logic [4:0] unit_id;
    logic passpw;
    logic coherent;
    logic isoc;
    logic derr;
    logic has_data;
    logic initial_frag;
    logic fwd_ok;
    logic [39:0] addr;
    logic [63:0] hdr_pay;
    logic [12:0] bytes_left;
    logic [11:0] frag_bc;
    logic [5:0] frag_dw;
    logic [5:0] req_left;
  } dmff_core_s;

  typedef struct packed {
    logic rs1;
    logic rs2;
    logic valid;
    logic ctl;
    logic [7:0] cad;
  } dmff_link_s;

  dmff_core_s c;
  dmff_core_s next_c;
  dmff_link_s l;
  dmff_link_s next_l;
  logic [11:0] bc_field;
  logic [39:0] cur_addr;
  logic [23:0] cur_data;
  logic [5:0] left_dw;
  logic [5:0] req_dw;
  logic chain_data;
  logic push_valid;
  logic push_ctl;
  logic [7:0] push_cad;
  logic fifo_w_ready;
  logic fifo_r_valid;
  logic fifo_r_ready;
  logic [8:0] fifo_r_data;

  //////////////////////////////////////////////////////////////////////////
  // one control bit-time of a request; shared by header and data requests
  function automatic logic [7:0] ctl_byte(
    input logic [2:0] bt,
    input logic [39:0] addr,
    input logic [3:0] seq_id,
    input logic [4:0] unit_id,
    input logic passpw,
    input logic isoc,
    input logic coherent,
    input logic chain,
    input logic derr,
    input logic [3:0] count
  );
    logic [7:0] b;
    b = 8'h00;
    unique case (bt)
      3'h0: b = {seq_id[3:2], dmff_pkg::CMD_PW_HI, isoc, coherent};
      3'h1: b = {passpw, seq_id[1:0], unit_id};
      3'h2: b = {count[1:0], 1'b0, derr, chain, 3'h0};
      3'h3: b = {2'h0, addr[5:2], count[3:2]};
      3'h4: b = addr[15:8];
      3'h5: b = addr[23:16];
      3'h6: b = addr[31:24];
      3'h7: b = addr[39:32];
    endcase
    return b;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // mapped fields of the current fragment
  always_comb
  begin
    // latched per fragment: the live count moves during the payload
    bc_field = c.frag_bc;
    cur_addr = c.addr;
    cur_addr[27:24] = bc_field[11:8];
    cur_addr[2] = c.initial_frag;
    cur_data = {bc_field[7:0], c.hdr_pay[15:0]};
    left_dw = (c.bytes_left > 13'(dmff_pkg::FRAG_MAX_DW) * 13'h0004)
      ? dmff_pkg::FRAG_MAX_DW
      : 6'((c.bytes_left + 13'h0003) >> 2);
    req_dw = (c.frag_dw > dmff_pkg::REQ_MAX_DW)
      ? dmff_pkg::REQ_MAX_DW : c.frag_dw;
    chain_data = c.frag_dw > req_dw;
  end

  assign xlat_addr = cur_addr;
  assign xlat_data = cur_data;
  assign pcix_fwd_ok = c.fwd_ok;
  assign busy = c.st != dmff_pkg::ST_IDLE;
  // a new message only when the previous fragment has fully entered the link fifo
  assign msg_ready = c.st == dmff_pkg::ST_IDLE;

  //////////////////////////////////////////////////////////////////////////
  // byte offered to the link fifo this cycle
  always_comb
  begin
    push_valid = 1'b0;
    push_ctl = 1'b0;
    push_cad = 8'h00;
    unique case (c.st)
      dmff_pkg::ST_IDLE:
      begin
        push_valid = 1'b0;
      end
      dmff_pkg::ST_HDR:
      begin
        push_valid = 1'b1;
        push_ctl = !c.bt[3];
        if (!c.bt[3])
          push_cad = ctl_byte(c.bt[2:0], cur_addr, c.seq_id, c.unit_id,
            c.passpw, c.isoc, c.coherent, c.has_data, 1'b0,
            dmff_pkg::HDR_COUNT);
        else if (c.bt == 4'hA)
          push_cad = bc_field[7:0];
        else
          push_cad = c.hdr_pay[8*c.bt[2:0] +: 8];
      end
      dmff_pkg::ST_DCTL:
      begin
        // same header fields; only chain, error and count differ
        push_valid = 1'b1;
        push_ctl = 1'b1;
        push_cad = ctl_byte(c.bt[2:0], cur_addr, c.seq_id, c.unit_id,
          c.passpw, c.isoc, c.coherent, chain_data, c.derr,
          4'(req_dw - 6'h01));
      end
      dmff_pkg::ST_DPAY:
      begin
        push_valid = pay_valid;
        push_cad = pay_data[8*c.bidx +: 8];
      end
    endcase
  end

  assign pay_ready = c.st == dmff_pkg::ST_DPAY && fifo_w_ready
    && c.bidx == 2'h3;

  //////////////////////////////////////////////////////////////////////////
  // fragment sequencer, core domain
  always_comb
  begin
    next_c = c;
    unique case (c.st)
      dmff_pkg::ST_IDLE:
      begin
        if (msg_valid)
        begin
          next_c.st = dmff_pkg::ST_HDR;
          next_c.bt = 4'h0;
          next_c.seq_id = msg_seq_id;
          next_c.unit_id = msg_unit_id;
          next_c.passpw = msg_relaxed;
          next_c.coherent = !msg_no_snoop;
          next_c.isoc = msg_isoc;
          next_c.derr = msg_data_err;
          next_c.has_data = msg_has_data;
          next_c.initial_frag = 1'b1;
          next_c.fwd_ok = msg_xlat_ok && msg_has_data;
          next_c.addr = {dmff_pkg::ADDR_HI_FE, dmff_pkg::ADDR_31_29,
            msg_type1, 4'h0,
            msg_route_host ? 8'h00 : msg_dst_bus,
            msg_route_host ? 5'h00 : msg_dst_dev,
            msg_route_host ? 3'h0 : msg_dst_fn,
            2'h0, msg_xlat_ok, msg_route_host, msg_silent,
            3'h0};
          next_c.hdr_pay = {msg_class, 8'h00, msg_src_bus, msg_src_dev,
            msg_src_fn};
          next_c.bytes_left = (msg_byte_count == 12'h000)
            ? dmff_pkg::BC_MAX : {1'b0, msg_byte_count};
          next_c.frag_bc = msg_has_data ? msg_byte_count : 12'h000;
        end
      end
      dmff_pkg::ST_HDR:
      begin
        if (fifo_w_ready)
        begin
          next_c.bt = c.bt + 4'h1;
          if (c.bt == dmff_pkg::HDR_LAST_BT)
          begin
            next_c.bt = 4'h0;
            next_c.frag_dw = left_dw;
            // no payload: the lone header closes the message
            next_c.st = c.has_data ? dmff_pkg::ST_DCTL
              : dmff_pkg::ST_IDLE;
          end
        end
      end
      dmff_pkg::ST_DCTL:
      begin
        if (fifo_w_ready)
        begin
          next_c.bt = c.bt + 4'h1;
          if (c.bt == dmff_pkg::CTL_LAST_BT)
          begin
            next_c.bt = 4'h0;
            next_c.bidx = 2'h0;
            next_c.req_left = req_dw;
            next_c.st = dmff_pkg::ST_DPAY;
          end
        end
      end
      dmff_pkg::ST_DPAY:
      begin
        if (fifo_w_ready && pay_valid)
        begin
          next_c.bidx = c.bidx + 2'h1;
          if (c.bidx == 2'h3)
          begin
            // last dword is padded; the count never goes below zero
            next_c.bytes_left = (c.bytes_left > dmff_pkg::DW_BYTES)
              ? c.bytes_left - dmff_pkg::DW_BYTES : 13'h0000;
            next_c.frag_dw = c.frag_dw - 6'h01;
            next_c.req_left = c.req_left - 6'h01;
            if (c.req_left == 6'h01)
            begin
              if (c.frag_dw != 6'h01)
                next_c.st = dmff_pkg::ST_DCTL;
              else if (c.bytes_left > dmff_pkg::DW_BYTES)
              begin
                next_c.st = dmff_pkg::ST_HDR;
                next_c.frag_bc = next_c.bytes_left[11:0];
                next_c.initial_frag = 1'b0;
              end
              else
                next_c.st = dmff_pkg::ST_IDLE;
            end
          end
        end
      end
    endcase
    if (!reset_n)
    begin
      next_c = '0;
      next_c.st = dmff_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge core_clk)
  begin
    c <= next_c;
  end

  //////////////////////////////////////////////////////////////////////////
  // crossing into the link clock; back-pressure stalls the sequencer
  dmff_fifo #(
    .WIDTH(dmff_pkg::FIFO_WIDTH),
    .DEPTH(dmff_pkg::FIFO_DEPTH)
  ) u_fifo (
    .wr_clk(core_clk),
    .wr_reset_n(reset_n),
    .wr_data({push_ctl, push_cad}),
    .wr_valid(push_valid),
    .wr_ready(fifo_w_ready),
    .rd_clk(link_clk),
    .rd_reset_n(l.rs2),
    .rd_data(fifo_r_data),
    .rd_valid(fifo_r_valid),
    .rd_ready(fifo_r_ready)
  );

  //////////////////////////////////////////////////////////////////////////
  // link output stage; reset reaches this domain through two flops
  assign fifo_r_ready = l.rs2 && (!l.valid || link_ready);
  assign link_valid = l.valid;
  assign link_ctl = l.ctl;
  assign link_cad = l.cad;

  always_comb
  begin
    next_l = l;
    next_l.rs1 = reset_n;
    next_l.rs2 = l.rs1;
    if (fifo_r_ready)
    begin
      next_l.valid = fifo_r_valid;
      next_l.ctl = fifo_r_data[8];
      next_l.cad = fifo_r_data[7:0];
    end
    if (!l.rs2)
    begin
      next_l.valid = 1'b0;
      next_l.ctl = 1'b0;
      next_l.cad = 8'h00;
    end
  end

  always_ff @(posedge link_clk)
  begin
    l <= next_l;
  end

endmodule

`default_nettype wire

// ===== design/dmff_pkg.sv
package dmff_pkg;

  // posted-write command: bits 5:2 fixed, bit 1 isoc, bit 0 coherent
  localparam logic [3:0] CMD_PW_HI = 4'hB;
  // fixed address bits of every device-message request
  localparam logic [7:0] ADDR_HI_FE = 8'hFE;
  localparam logic [2:0] ADDR_31_29 = 3'h0;
  // bit-time counts and positions
  localparam logic [3:0] HDR_LAST_BT = 4'hF;
  localparam logic [3:0] CTL_LAST_BT = 4'h7;
  localparam logic [3:0] HDR_COUNT = 4'h1;
  // doubleword limits: 64 bytes per request, 128 bytes per fragment
  localparam logic [5:0] REQ_MAX_DW = 6'h10;
  localparam logic [5:0] FRAG_MAX_DW = 6'h20;
  // byte count field 000h stands for 4096 bytes
  localparam logic [12:0] BC_MAX = 13'h1000;
  localparam logic [12:0] DW_BYTES = 13'h0004;
  // link fifo shape: one bit-time plus its control flag
  localparam int FIFO_WIDTH = 9;
  localparam int FIFO_DEPTH = 16;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_HDR,
    ST_DCTL,
    ST_DPAY
  } dmff_state_e;

endpackage

// ===== design/dmff_fifo.sv
`timescale 1ns/100ps
`default_nettype none

module dmff_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic wr_clk, // filling side clock
  input wire logic wr_reset_n, // filling side sync reset
  input wire logic [WIDTH-1:0] wr_data, // word in
  input wire logic wr_valid, // word offered
  output logic wr_ready, // room for a word
  input wire logic rd_clk, // draining side clock
  input wire logic rd_reset_n, // draining side sync reset
  output logic [WIDTH-1:0] rd_data, // word out
  output logic rd_valid, // word available
  input wire logic rd_ready // word taken
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] bin;
    logic [AW:0] gray;
    logic [AW:0] sync1;
    logic [AW:0] sync2;
  } dmff_wr_s;

  typedef struct packed {
    logic [AW:0] bin;
    logic [AW:0] gray;
    logic [AW:0] sync1;
    logic [AW:0] sync2;
  } dmff_rd_s;

  dmff_wr_s w;
  dmff_wr_s next_w;
  dmff_rd_s r;
  dmff_rd_s next_r;
  logic [AW:0] wbin_inc;
  logic [AW:0] rbin_inc;

  //////////////////////////////////////////////////////////////////////////
  // write side: gray pointers so only one bit moves per crossing
  assign wr_ready = w.gray != {~w.sync2[AW:AW-1], w.sync2[AW-2:0]};
  assign wbin_inc = w.bin + 1'b1;

  always_comb
  begin
    next_w = w;
    next_w.sync1 = r.gray;
    next_w.sync2 = w.sync1;
    if (wr_valid && wr_ready)
    begin
      next_w.mem[w.bin[AW-1:0]] = wr_data;
      next_w.bin = wbin_inc;
      next_w.gray = wbin_inc ^ (wbin_inc >> 1);
    end
    if (!wr_reset_n)
    begin
      next_w.bin = '0;
      next_w.gray = '0;
      next_w.sync1 = '0;
      next_w.sync2 = '0;
    end
  end

  always_ff @(posedge wr_clk)
  begin
    w <= next_w;
  end

  //////////////////////////////////////////////////////////////////////////
  // read side: memory word read straight from the storage flops
  assign rd_valid = r.gray != r.sync2;
  assign rd_data = w.mem[r.bin[AW-1:0]];
  assign rbin_inc = r.bin + 1'b1;

  always_comb
  begin
    next_r = r;
    next_r.sync1 = w.gray;
    next_r.sync2 = r.sync1;
    if (rd_valid && rd_ready)
    begin
      next_r.bin = rbin_inc;
      next_r.gray = rbin_inc ^ (rbin_inc >> 1);
    end
    if (!rd_reset_n)
    begin
      next_r = '0;
    end
  end

  always_ff @(posedge rd_clk)
  begin
    r <= next_r;
  end

endmodule

`default_nettype wire

// ===== tb/dmff_checker.sv
`timescale 1ns/100ps
`default_nettype none
module dmff_checker (
  input wire logic core_clk, // core clock
  input wire logic reset_n, // sync reset
  input wire logic msg_valid, // header offered
  input wire logic msg_ready, // header taken
  input wire logic msg_route_host, // to host
  input wire logic msg_xlat_ok, // xlat ok
  input wire logic msg_silent, // silent drop
  input wire logic msg_has_data, // payload
  input wire logic [11:0] msg_byte_count, // bytes
  input wire logic pay_ready, // dword taken
  input wire logic busy, // in progress
  input wire logic [39:0] xlat_addr, // mapped addr
  input wire logic [23:0] xlat_data, // mapped data
  input wire logic pcix_fwd_ok, // pci-x ok
  input wire logic link_clk, // link clock
  input wire logic link_ready, // sink ready
  input wire logic link_valid, // bit-time valid
  input wire logic [7:0] link_cad // bit-time byte
);
  logic took;
  // take seen last edge; gated so nothing in reset counts as one
  always_ff @(posedge core_clk)
    took <= reset_n && msg_valid && msg_ready;

  chk_addr_fixed: assert property (@(posedge core_clk)
    disable iff (!reset_n) busy |-> xlat_addr[39:29] == 11'h7F0)
    else $error("fixed address bits wrong");
  chk_no_insert: assert property (@(posedge core_clk)
    disable iff (!reset_n) took |-> (busy && !msg_ready) [*8])
    else $error("header taken inside a message");
  chk_flag_map: assert property (@(posedge core_clk)
    disable iff (!reset_n) took |-> xlat_addr[5:2] == {$past(msg_xlat_ok),
    $past(msg_route_host), $past(msg_silent), 1'b1})
    else $error("flag bits wrong");
  chk_host_zero: assert property (@(posedge core_clk)
    disable iff (!reset_n) took && $past(msg_route_host)
    |-> xlat_addr[23:8] == 16'h0000)
    else $error("completer id not cleared");
  chk_bc_map: assert property (@(posedge core_clk)
    disable iff (!reset_n) took && $past(msg_has_data)
    |-> {xlat_addr[27:24], xlat_data[23:16]} == $past(msg_byte_count))
    else $error("byte count mapping wrong");
  chk_pcix_ok: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    took |-> pcix_fwd_ok == $past(msg_xlat_ok && msg_has_data))
    else $error("pci-x permission wrong");
  chk_nodata_pay: assert property (@(posedge core_clk)
    disable iff (!reset_n) took && !$past(msg_has_data) |-> !pay_ready [*8])
    else $error("payload taken without data");
  chk_link_hold: assert property (@(posedge link_clk)
    disable iff (!reset_n) link_valid && !link_ready
    |=> link_valid && $stable(link_cad))
    else $error("bit-time dropped before taken");

  cov_data: cover property (@(posedge core_clk) took && $past(msg_has_data));
  cov_pay: cover property (@(posedge core_clk) pay_ready);
  cov_stall: cover property (@(posedge link_clk) link_valid && !link_ready);
endmodule
bind dmff_framer dmff_checker i_chk (.*);
`default_nettype wire

// ===== tb/dmff_link_sink.sv
`timescale 1ns/100ps
`default_nettype none
module dmff_link_sink (
  input wire logic link_clk, // link clock
  input wire logic stall, // hold sender off
  input wire logic link_valid, // bit-time offered
  input wire logic link_ctl, // control flag
  input wire logic [7:0] link_cad, // bit-time byte
  output logic link_ready // bit-time accepted
);
  logic [8:0] q [$];
  logic [1:0] ph = 2'h0;
  initial
    link_ready = 1'h0;
  // refuse every fourth beat so the sender must hold its bit-time
  always @(posedge link_clk)
  begin
    ph <= ph + 2'h1;
    link_ready <= !stall && ph != 2'h3;
    if (link_valid && link_ready)
      q.push_back({link_ctl, link_cad});
  end
endmodule
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  typedef struct packed {
    logic [11:0] bc;
    logic dat;
    logic host;
    logic xok;
    logic sil;
    logic pcix;
    logic [10:0] dw;
  } dmff_row_s;
  logic core_clk = 1'h0;
  logic link_clk = 1'h0;
  logic reset_n = 1'h0;
  logic stall = 1'h0;
  logic msg_valid = 1'h0;
  logic pay_valid = 1'h1;
  logic msg_relaxed, msg_no_snoop, msg_isoc, msg_xlat_ok, msg_route_host;
  logic msg_silent, msg_type1, msg_has_data, msg_data_err;
  logic [3:0] msg_seq_id;
  logic [4:0] msg_unit_id, msg_dst_dev, msg_src_dev;
  logic [2:0] msg_dst_fn, msg_src_fn;
  logic [7:0] msg_dst_bus, msg_src_bus, link_cad;
  logic [11:0] msg_byte_count;
  logic [39:0] msg_class, xlat_addr;
  logic [23:0] xlat_data;
  logic [7:0] b = 8'h00;
  logic [7:0] pb = 8'h00;
  logic msg_ready, pay_ready, busy, pcix_fwd_ok;
  logic link_ready, link_valid, link_ctl;
  int bad_count = 0;
  int comparisons = 0;
  int cyc = 0;
  int n_dw = 0;
  // bytes of each dword count up, so the link stream is checkable
  wire [31:0] pay_data = {b + 8'h03, b + 8'h02, b + 8'h01, b};
  dmff_row_s rows [6] = '{
    '{12'h004, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 11'h001},
    '{12'h001, 1'h1, 1'h1, 1'h0, 1'h1, 1'h0, 11'h001},
    '{12'h041, 1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 11'h011},
    '{12'h0C8, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 11'h032},
    '{12'h123, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 11'h000},
    '{12'h000, 1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 11'h400}};

  dmff_framer i_dut (.*);
  dmff_link_sink i_sink (.link_clk(link_clk), .stall(stall),
    .link_valid(link_valid), .link_ctl(link_ctl), .link_cad(link_cad),
    .link_ready(link_ready));

  // clocks: 200 MHz core, 6 ns link
  always #2.5 core_clk = ~core_clk;
  always #3 link_clk = ~link_clk;

  // the largest message needs about 8200 cycles; the ceiling allows slack
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      conclude();
    end
  end

  // step to the next dword once the current one is taken
  always @(posedge core_clk)
    if (pay_valid && pay_ready)
    begin
      b <= b + 8'h04;
      n_dw++;
    end

  task automatic conclude;
    if (bad_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string s, input logic [39:0] e, g);
    comparisons++;
    if (g !== e)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask

  // offer one header and hold it until taken
  task automatic start(input logic [15:0] k, input dmff_row_s w);
    @(posedge core_clk);
    msg_seq_id <= k[3:0];
    msg_unit_id <= k[4:0] + 5'h03;
    {msg_relaxed, msg_no_snoop, msg_isoc} <= k[2:0];
    {msg_type1, msg_data_err} <= k[1:0] ^ 2'h2;
    {msg_dst_bus, msg_dst_dev, msg_dst_fn} <= 16'h5A3C + k;
    {msg_src_bus, msg_src_dev, msg_src_fn} <= 16'hC35A - k;
    msg_class <= {5{k[7:0] ^ 8'h96}};
    {msg_byte_count, msg_has_data, msg_route_host} <= {w.bc, w.dat, w.host};
    {msg_xlat_ok, msg_silent} <= {w.xok, w.sil};
    msg_valid <= 1'h1;
    n_dw = 0;
    i_sink.q.delete();
    do @(posedge core_clk); while (!msg_ready);
    msg_valid <= 1'h0;
  endtask

  // walk the captured link stream fragment by fragment
  task automatic parse(input dmff_row_s w);
    logic [7:0] h [16];
    logic [7:0] m [8];
    logic [8:0] q [$];
    logic ch;
    int p, n, fb, tot, rem, fr;
    m = '{8'hFF, 8'hFF, 8'h27, 8'hFC, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
    q = i_sink.q;
    rem = (w.bc == 12'h000) ? 4096 : int'(w.bc);
    p = 0;
    fr = 0;
    tot = 0;
    while (p + 16 <= q.size())
    begin
      foreach (h[j])
        h[j] = q[p+j][7:0];
      chk("hdr0", {1'h1, msg_seq_id[3:2], 4'hB, msg_isoc, !msg_no_snoop},
        q[p]);
      chk("hdr1", {msg_relaxed, msg_seq_id[1:0], msg_unit_id}, h[1]);
      chk("hdr2", {4'h4, w.dat, 3'h0}, h[2]);
      chk("hdr3", {w.xok, w.host, w.sil, fr == 0}, h[3][7:2]);
      chk("hdr_dst", w.host ? 16'h0000 : {msg_dst_bus, msg_dst_dev,
        msg_dst_fn}, {h[5], h[4]});
      chk("hdr_top", {8'hFE, 3'h0, msg_type1}, {h[7], h[6][7:4]});
      chk("hdr_src", {msg_src_bus, msg_src_dev, msg_src_fn},
        {h[9], h[8]});
      chk("hdr_cls", msg_class, {h[15], h[14], h[13], h[12], h[11]});
      if (w.dat)
        chk("hdr_bc", rem[11:0], {h[6][3:0], h[10]});
      p += 16;
      fb = 0;
      ch = w.dat;
      while (ch && p + 8 <= q.size())
      begin
        for (int j = 0; j < 8; j++)
          chk("dctl", h[j] & m[j], q[p+j][7:0] & m[j]);
        chk("derr", {1'h1, msg_data_err}, {q[p][8], q[p+2][4]});
        ch = q[p+2][3];
        n = 4 * ({q[p+3][1:0], q[p+2][7:6]} + 1);
        p += 8;
        for (int j = 0; j < n; j++)
        begin
          chk("data", {1'h0, pb}, q[p+j]);
          pb++;
        end
        p += n;
        fb += n;
      end
      chk("frag_len", w.dat ? (rem > 128 ? 128 : (rem + 3) / 4 * 4) : 0,
        fb);
      tot += fb;
      rem -= 128;
      fr++;
    end
    chk("total", {w.dw, 2'h0}, tot);
    chk("tail", q.size(), p);
  endtask

  // wait out the message and the link drain, then check the stream
  task automatic finish_msg(input dmff_row_s w);
    @(posedge core_clk);
    while (busy)
      @(posedge core_clk);
    do repeat (8) @(posedge core_clk); while (link_valid);
    parse(w);
  endtask

  // main sequence: reset, table of messages, then a stalled link
  initial
  begin
    {msg_seq_id, msg_unit_id, msg_relaxed, msg_no_snoop, msg_isoc,
      msg_xlat_ok, msg_route_host, msg_silent, msg_type1, msg_has_data,
      msg_data_err, msg_byte_count, msg_dst_bus, msg_dst_dev, msg_dst_fn,
      msg_src_bus, msg_src_dev, msg_src_fn, msg_class} = '0;
    repeat (5) @(posedge core_clk);
    chk("reset", 4'h8, {msg_ready, busy, pay_ready, link_valid});
    reset_n <= 1'h1;
    for (int r = 0; r < 6; r++)
    begin
      start(r[15:0], rows[r]);
      finish_msg(rows[r]);
      chk("pcix", rows[r].pcix, pcix_fwd_ok);
      chk("dwords", rows[r].dw, n_dw);
    end
    // fifo fills before the first dword is due, so none may be taken
    stall <= 1'h1;
    start(16'h0007, rows[3]);
    repeat (80) @(posedge core_clk);
    chk("stall_dw", 0, n_dw);
    chk("stall_out", 2'h2, {link_valid, link_ready});
    stall <= 1'h0;
    finish_msg(rows[3]);
    conclude();
  end
endmodule
`default_nettype wire
